//--- verif/mux_bus_monitor.sv
// Concurrent checks on the shared bus lines between the two ends.
`timescale 1ns/1ps
module mux_bus_monitor (
  // Clock and reset.
  input wire logic        sys_clk,
  input wire logic        resetn,
  // Bus lines.
  input wire logic        clockA,
  input wire logic        clockB,
  input wire logic [11:0] addrBusLine,
  input wire logic        writeIoLine,
  input wire logic [7:0]  cpuIdOut,
  input wire logic [7:0]  cpuIdOe,
  input wire logic [7:0]  memIdOut,
  input wire logic [7:0]  memIdOe,
  input wire logic [7:0]  instrDataBusLine
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  mux_bus_pkg::phase_e ph;
  mux_bus_pkg::phase_e phPrev;
  logic [1:0]          phCnt;
  logic                ioArmed;
  logic                inPh;
  logic                quiet;
  assign ph    = mux_bus_pkg::decode_phase(clockA, clockB);
  assign inPh  = (ph == phPrev);
  assign quiet = inPh && (phCnt != 2'h0) && (ph == mux_bus_pkg::PH1 || ph == mux_bus_pkg::PH3);
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) phPrev <= mux_bus_pkg::PH1;
    else phPrev <= ph;
  end
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) phCnt <= 2'h0;
    else if (!inPh) phCnt <= 2'h1;
    else if (phCnt != 2'h3) phCnt <= phCnt + 2'h1;
  end
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) ioArmed <= 1'b0;
    else if (ph == mux_bus_pkg::PH4 && inPh && phCnt == 2'h2 && writeIoLine) ioArmed <= 1'b1;
    else if (ph == mux_bus_pkg::PH3) ioArmed <= 1'b0;
  end
  property p_addr_zero; quiet |-> addrBusLine == 12'h000; endproperty
  a_addr_zero: assert property (p_addr_zero) else $error("address lines not cleared");
  property p_wio_zero; quiet |-> !writeIoLine; endproperty
  a_wio_zero: assert property (p_wio_zero) else $error("write line not cleared");
  property p_data_zero; quiet |-> instrDataBusLine == 8'h00; endproperty
  a_data_zero: assert property (p_data_zero) else $error("data lines not cleared");
  property p_addr_hold;
    (ph == mux_bus_pkg::PH4 && inPh && phCnt == 2'h2) |-> $stable(addrBusLine) && $stable(writeIoLine);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved within phase four");
  property p_fetch_free; (ph == mux_bus_pkg::PH4 && inPh && phCnt != 2'h0) |-> cpuIdOe == mux_bus_pkg::OE_NONE;
  endproperty
  a_fetch_free: assert property (p_fetch_free) else $error("processor drove data during fetch");
  property p_cmd_rom; (ph == mux_bus_pkg::PH4 && inPh && phCnt == 2'h2 && writeIoLine) |-> memIdOe == 8'hFF;
  endproperty
  a_cmd_rom: assert property (p_cmd_rom) else $error("command byte not supplied");
  property p_ram_split; (ph == mux_bus_pkg::PH2 && inPh && phCnt == 2'h2 && writeIoLine)
    |-> cpuIdOe == mux_bus_pkg::OE_LOW_HALF && memIdOe == mux_bus_pkg::OE_HIGH_HALF; endproperty
  a_ram_split: assert property (p_ram_split) else $error("data halves wrong in RAM exchange");
  property p_io_split; (ph == mux_bus_pkg::PH2 && inPh && phCnt == 2'h2 && ioArmed)
    |-> cpuIdOe == mux_bus_pkg::OE_LOW_HALF && memIdOe == mux_bus_pkg::OE_HIGH_HALF; endproperty
  a_io_split: assert property (p_io_split) else $error("data halves wrong in port exchange");
  property p_io_no_write; (ph == mux_bus_pkg::PH2 && ioArmed) |-> !writeIoLine; endproperty
  a_io_no_write: assert property (p_io_no_write) else $error("RAM write during port exchange");
  property p_lines_released; (quiet && phCnt == 2'h2)
    |-> memIdOe == mux_bus_pkg::OE_NONE && memIdOut == 8'h00 && cpuIdOut == 8'h00; endproperty
  a_lines_released: assert property (p_lines_released) else $error("data drivers not released");
  c_io: cover property (ph == mux_bus_pkg::PH2 && ioArmed && phCnt == 2'h2);
  c_ram: cover property (ph == mux_bus_pkg::PH2 && writeIoLine);
  c_cmd: cover property (ph == mux_bus_pkg::PH4 && writeIoLine);
endmodule : mux_bus_monitor

//--- verif/tb_multiplexed_system_bus.sv
// Testbench joining both bus ends and checking exchanges, port transfers and paging.
`timescale 1ns/1ps
module tb_multiplexed_system_bus;
  localparam logic [11:0] START_PC = 12'h0C0;
  logic        sys_clk, resetn, run, romLoadEn, accLoad, pointerLoad, ioDataReady, ioDataValid, ioStrobe;
  logic [1:0]  phaseAB, phTick, romSelect;
  logic [11:0] romLoadAddr, pointerValue, programCounter, ramPointer, upperReturnStack, lowerReturnStack;
  logic [7:0]  romLoadData, ioCommand;
  logic [3:0]  accValue, ioInput, ioData, ioOutput, accumulator, secondaryAcc, lowDigit, midDigit, highDigit;
  logic [5:0]  pageNumber, pageLocation;
  logic [3:0]  got[$];
  int          bad_count, n_compared, k, seen;
  logic [19:0] prog [15] = '{20'h0_C02D, 20'h0_C12D, 20'h0_C21C, 20'h0_C337, 20'h0_C41A, 20'h0_C51C, 20'h0_C637,
                             20'h0_C71C, 20'h0_C837, 20'h0_C9D0, 20'h0_CABE, 20'h0_D0E0, 20'h0_D105,
                             20'h0_E005, 20'h0_FEBE};
  mux_bus_if mux_bus_if_i ();
  assign mux_bus_if_i.clockA = phaseAB[1];
  assign mux_bus_if_i.clockB = phaseAB[0];
  bus_processor_end #(.RESET_PC(START_PC)) bus_processor_end_i (.sys_clk(sys_clk), .resetn(resetn),
    .bus(mux_bus_if_i.cpu), .accLoad(accLoad), .accValue(accValue), .pointerLoad(pointerLoad),
    .pointerValue(pointerValue), .ioDataValid(ioDataValid), .ioDataReady(ioDataReady), .ioData(ioData),
    .programCounter(programCounter), .pageNumber(pageNumber), .pageLocation(pageLocation),
    .ramPointer(ramPointer), .ramPointerLowDigit(lowDigit), .ramPointerMidDigit(midDigit),
    .ramPointerHighDigit(highDigit), .upperReturnStack(upperReturnStack), .lowerReturnStack(lowerReturnStack),
    .accumulator(accumulator), .secondaryAcc(secondaryAcc));
  bus_memory_end bus_memory_end_i (.sys_clk(sys_clk), .resetn(resetn), .bus(mux_bus_if_i.mem),
    .romSelect(romSelect), .ramSelect(1'h1), .romLoadEn(romLoadEn), .romLoadAddr(romLoadAddr),
    .romLoadData(romLoadData), .ioInput(ioInput), .ioOutput(ioOutput), .ioCommand(ioCommand),
    .ioStrobe(ioStrobe));
  mux_bus_monitor mux_bus_monitor_i (.sys_clk(sys_clk), .resetn(resetn), .clockA(mux_bus_if_i.clockA),
    .clockB(mux_bus_if_i.clockB), .addrBusLine(mux_bus_if_i.addrBusLine),
    .writeIoLine(mux_bus_if_i.writeIoLine), .cpuIdOut(mux_bus_if_i.cpuIdOut), .cpuIdOe(mux_bus_if_i.cpuIdOe),
    .memIdOut(mux_bus_if_i.memIdOut), .memIdOe(mux_bus_if_i.memIdOe),
    .instrDataBusLine(mux_bus_if_i.instrDataBusLine));
  always #5 sys_clk = ~sys_clk;
  // Phase clocks step through phases one to four, three system clocks each.
  always @(negedge sys_clk) begin
    if (!run || phTick == 2'h2) phTick <= 2'h0;
    else phTick <= phTick + 2'h1;
    if (!run) phaseAB <= 2'h3;
    else if (phTick == 2'h2) phaseAB <= phaseAB - 2'h1;
  end
  task automatic test_done();
    $display("Compared %0d values, %0d mismatches", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : test_done
  task automatic check(input string what, input logic [11:0] exp, input logic [11:0] seenVal);
    n_compared++;
    if (seenVal !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seenVal);
    end
  endtask : check
  task automatic timed_out(input string what);
    bad_count++;
    $display("FAIL %s expected event seen timeout", what);
    test_done();
  endtask : timed_out
  task automatic wait_strobe();
    for (k = 0; k < 400 && ioStrobe !== 1'b1; k++) @(negedge sys_clk);
    if (k == 400) timed_out("ioStrobe");
  endtask : wait_strobe
  task automatic wait_pc(input logic [11:0] pc);
    for (k = 0; k < 400 && programCounter !== pc; k++) @(negedge sys_clk);
    if (k == 400) timed_out("programCounter");
  endtask : wait_pc
  task automatic do_reset();
    run = 1'b0;
    @(negedge sys_clk);
    resetn = 1'b0;
    repeat (20) @(negedge sys_clk);
    resetn = 1'b1;
    @(negedge sys_clk);
    check("programCounter", START_PC, programCounter);
    check("upperReturnStack", 12'h000, upperReturnStack);
  endtask : do_reset
  initial begin
    {sys_clk, run, romLoadEn, accLoad, pointerLoad, ioDataReady, phTick} = '0;
    {romLoadAddr, romLoadData, accValue, pointerValue} = '0;
    {resetn, bad_count, n_compared} = '0;
    phaseAB = 2'h3;
    romSelect = 2'h3;
    ioInput = 4'h9;
    do_reset();
    check("accumulator", 12'h000, {8'h00, accumulator});
    check("ioDataValid", 12'h000, {11'h000, ioDataValid});
    foreach (prog[i]) begin
      romLoadEn = 1'b1;
      {romLoadAddr, romLoadData} = prog[i];
      @(negedge sys_clk);
    end
    {romLoadEn, accLoad, pointerLoad, accValue, pointerValue} = {3'h3, 4'h5, 12'h123};
    @(negedge sys_clk);
    {accLoad, pointerLoad} = 2'h0;
    @(negedge sys_clk);
    check("ramPointer digits", 12'h321, {lowDigit, midDigit, highDigit});
    $display("reset and load test done");
    run = 1'b1;
    wait_strobe();
    check("ioOutput", 12'h00A, {8'h00, ioOutput});
    check("ioCommand", 12'h037, {4'h0, ioCommand});
    ioInput = 4'hC;
    @(negedge sys_clk);
    wait_strobe();
    check("ioOutput", 12'h00F, {8'h00, ioOutput});
    check("secondaryAcc", 12'h006, {8'h00, secondaryAcc});
    seen = 0;
    repeat (60) begin
      @(negedge sys_clk);
      seen += (ioStrobe === 1'b1);
    end
    check("stalled strobes", 12'h000, seen[11:0]);
    check("stalled programCounter", START_PC + 12'h008, programCounter);
    check("stalled ioData", 12'h106, {3'h0, ioDataValid, 4'h0, ioData});
    $display("port transfer and stall test done");
    ioDataReady = 1'b1;
    for (k = 0; k < 300 && got.size() < 3; k++) begin
      if (ioDataValid === 1'b1) got.push_back(ioData);
      @(negedge sys_clk);
    end
    check("drained words", 12'h003, 12'(got.size()));
    if (got.size() == 3) check("drained data", 12'h633, {got[0], got[1], got[2]});
    check("ioOutput", 12'h00C, {8'h00, ioOutput});
    $display("drain test done");
    wait_pc(START_PC + 12'h010);
    repeat (2) @(negedge sys_clk);
    check("upperReturnStack", 12'h0CA, upperReturnStack);
    wait_pc(12'h0E0);
    check("nested upperReturnStack", 12'h0D1, upperReturnStack);
    check("nested lowerReturnStack", 12'h0CA, lowerReturnStack);
    wait_pc(12'h0FE);
    repeat (40) @(negedge sys_clk);
    check("popped upperReturnStack", 12'h0CA, upperReturnStack);
    check("pageNumber", 12'h003, {6'h00, pageNumber});
    check("pageLocation", 12'h03E, {6'h00, pageLocation});
    $display("paging test done");
    romSelect = 2'h1;
    wait_pc(12'h100);
    check("unselected ROM pageNumber", 12'h004, {6'h00, pageNumber});
    $display("chip select test done");
    do_reset();
    $display("second reset test done");
    test_done();
  end
endmodule : tb_multiplexed_system_bus

//--- verilog/bus_memory_end.sv
// Program memory, data RAM and one I/O circuit on the far side of the shared bus.
`timescale 1ns/1ps
module bus_memory_end #(
  parameter int         ROM_DEPTH = mux_bus_pkg::MEM_DEPTH,
  parameter int         RAM_DEPTH = mux_bus_pkg::MEM_DEPTH,
  parameter logic [3:0] IO_SELECT = 4'h3
) (
  // Clock and reset.
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  // Shared bus.
  mux_bus_if.mem          bus,
  // Chip selects.
  input  wire logic [1:0] romSelect,
  input  wire logic       ramSelect,
  // Program memory loading.
  input  wire logic       romLoadEn,
  input  wire logic [11:0] romLoadAddr,
  input  wire logic [7:0] romLoadData,
  // I/O circuit user side.
  input  wire logic [3:0] ioInput,
  output logic      [3:0] ioOutput,
  output logic      [7:0] ioCommand,
  output logic            ioStrobe
);

  logic [7:0] rom [ROM_DEPTH];
  logic [3:0] ram [RAM_DEPTH];

  mux_bus_pkg::phase_e curPhase;
  mux_bus_pkg::phase_e memPhase;
  logic                fresh;
  logic                ramBlocked;
  logic                ioArmed;
  logic                romEnabled;
  logic [7:0]          romByte;
  logic [3:0]          ramDigit;

  assign curPhase   = mux_bus_pkg::decode_phase(bus.clockA, bus.clockB); // RL17
  assign romEnabled = &romSelect; // RL3 RL4
  assign romByte    = rom[bus.addrBusLine];
  assign ramDigit   = ram[bus.addrBusLine];

  always_ff @(posedge sys_clk) begin
    if (romLoadEn) begin
      rom[romLoadAddr] <= romLoadData;
    end
  end

  // One cycle after a phase change the processor's address is settled; act then.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      memPhase <= mux_bus_pkg::PH1;
      fresh    <= 1'b0;
    end else begin
      memPhase <= curPhase;
      fresh    <= (curPhase != memPhase);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (fresh && memPhase == mux_bus_pkg::PH2 && ramSelect && !ramBlocked && bus.writeIoLine) begin // RL5 RL6 RL20
      ram[bus.addrBusLine] <= bus.instrDataBusLine[3:0]; // RL7
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      bus.memIdOut <= mux_bus_pkg::BYTE_ZERO;
      bus.memIdOe  <= mux_bus_pkg::OE_NONE;
      ramBlocked   <= 1'b0;
      ioArmed      <= 1'b0;
      ioOutput     <= 4'h0;
      ioCommand    <= mux_bus_pkg::BYTE_ZERO;
      ioStrobe     <= 1'b0;
    end else begin
      ioStrobe <= 1'b0;
      if (fresh) begin
        bus.memIdOut <= mux_bus_pkg::BYTE_ZERO; // RL18
        bus.memIdOe  <= mux_bus_pkg::OE_NONE;
        unique case (memPhase)
          mux_bus_pkg::PH2: begin
            if (ramBlocked) begin // RL8
              if (ioArmed) begin // RL12
                bus.memIdOut <= {ioInput, 4'h0};
                bus.memIdOe  <= mux_bus_pkg::OE_HIGH_HALF;
                ioOutput     <= bus.instrDataBusLine[3:0];
                ioStrobe     <= 1'b1;
              end
            end else if (ramSelect) begin
              bus.memIdOut <= {ramDigit, 4'h0}; // RL6 RL7
              bus.memIdOe  <= mux_bus_pkg::OE_HIGH_HALF;
            end
            ramBlocked <= 1'b0;
            ioArmed    <= 1'b0;
          end
          mux_bus_pkg::PH4: begin
            if (romEnabled) begin
              bus.memIdOut <= romByte;
              bus.memIdOe  <= mux_bus_pkg::OE_ALL;
            end
            ramBlocked <= bus.writeIoLine; // RL8
            if (bus.writeIoLine && romEnabled) begin // RL11
              ioCommand <= romByte;
              ioArmed   <= (romByte[mux_bus_pkg::IO_SEL_LSB +: 4] == IO_SELECT);
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

endmodule : bus_memory_end

//--- verilog/bus_processor_end.sv
// Processor end of the multiplexed bus: phase sequencing, fetch, RAM exchange and I/O transfer.
`timescale 1ns/1ps
module bus_processor_end #(
  parameter logic [11:0] RESET_PC = mux_bus_pkg::PC_RESET
) (
  // Clock and reset.
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // Shared bus.
  mux_bus_if.cpu           bus,
  // Accumulator and RAM pointer loading.
  input  wire logic        accLoad,
  input  wire logic [3:0]  accValue,
  input  wire logic        pointerLoad,
  input  wire logic [11:0] pointerValue,
  // I/O data stream.
  output wire logic        ioDataValid,
  input  wire logic        ioDataReady,
  output wire logic [3:0]  ioData,
  // Register view.
  output logic      [11:0] programCounter,
  output wire logic [5:0]  pageNumber,
  output wire logic [5:0]  pageLocation,
  output logic      [11:0] ramPointer,
  output wire logic [3:0]  ramPointerLowDigit,
  output wire logic [3:0]  ramPointerMidDigit,
  output wire logic [3:0]  ramPointerHighDigit,
  output logic      [11:0] upperReturnStack,
  output logic      [11:0] lowerReturnStack,
  output logic      [3:0]  accumulator,
  output logic      [3:0]  secondaryAcc
);

  typedef enum logic [1:0] {ST_RUN, ST_PORT_CMD, ST_PORT_XFER} cpu_state_e;

  mux_bus_pkg::phase_e phase;
  mux_bus_pkg::phase_e next_phase;
  cpu_state_e          state;
  logic [7:0]          pendingOp;
  logic                phaseEnd;
  logic                fetchEnd;
  logic                exchangeEnd;
  logic [7:0]          fetched;
  logic [3:0]          busDigit;
  logic [11:0]         nextPc;
  logic                bufInReady;
  logic                bufInValid;
  logic                isExchange;
  logic                isSwap;

  assign next_phase  = mux_bus_pkg::decode_phase(bus.clockA, bus.clockB); // RL17
  assign phaseEnd    = (next_phase != phase);
  assign fetchEnd    = phaseEnd && (phase == mux_bus_pkg::PH4);
  assign exchangeEnd = phaseEnd && (phase == mux_bus_pkg::PH2);
  assign fetched     = bus.instrDataBusLine;
  assign busDigit    = ~bus.instrDataBusLine[7:4]; // RL19
  assign nextPc      = programCounter + 12'h001;
  assign isExchange  = (state == ST_RUN) && (pendingOp == mux_bus_pkg::EXCHANGE_OP);
  assign isSwap      = (state == ST_RUN) && (pendingOp == mux_bus_pkg::SWAP_ACC_OP);
  assign bufInValid  = exchangeEnd && (state == ST_PORT_XFER);

  assign pageNumber          = programCounter[mux_bus_pkg::PAGE_LSB +: mux_bus_pkg::PAGE_W]; // RL14
  assign pageLocation        = programCounter[0 +: mux_bus_pkg::PAGE_W]; // RL13
  assign ramPointerLowDigit  = ramPointer[mux_bus_pkg::LOW_DIGIT_LSB +: mux_bus_pkg::DIGIT_W]; // RL15
  assign ramPointerMidDigit  = ramPointer[mux_bus_pkg::MID_DIGIT_LSB +: mux_bus_pkg::DIGIT_W]; // RL15
  assign ramPointerHighDigit = ramPointer[mux_bus_pkg::HIGH_DIGIT_LSB +: mux_bus_pkg::DIGIT_W]; // RL15

  // Words taken from an I/O circuit wait here until the user side accepts them.
  two_entry_buffer #(
    .WIDTH (mux_bus_pkg::DIGIT_W)
  ) ioBuffer (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .inValid  (bufInValid),
    .inReady  (bufInReady),
    .inData   (busDigit),
    .outValid (ioDataValid),
    .outReady (ioDataReady),
    .outData  (ioData)
  );

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      phase <= mux_bus_pkg::PH1;
    end else begin
      phase <= next_phase;
    end
  end

  // Bus lines are set on entry to each phase and held for the whole phase.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      bus.addrBusLine <= 12'h000;
      bus.writeIoLine <= 1'b0;
      bus.cpuIdOut    <= mux_bus_pkg::BYTE_ZERO;
      bus.cpuIdOe     <= mux_bus_pkg::OE_NONE;
    end else if (phaseEnd) begin
      unique case (next_phase)
        mux_bus_pkg::PH2: begin
          bus.addrBusLine <= ramPointer; // RL2
          bus.writeIoLine <= isExchange; // RL5
          bus.cpuIdOut    <= {4'h0, ~accumulator}; // RL7 RL19
          bus.cpuIdOe     <= mux_bus_pkg::OE_LOW_HALF;
        end
        mux_bus_pkg::PH4: begin
          bus.addrBusLine <= programCounter; // RL2
          bus.writeIoLine <= (state == ST_PORT_CMD) && bufInReady; // RL11
          bus.cpuIdOut    <= mux_bus_pkg::BYTE_ZERO;
          bus.cpuIdOe     <= mux_bus_pkg::OE_NONE;
        end
        default: begin
          bus.addrBusLine <= 12'h000; // RL18
          bus.writeIoLine <= 1'b0;
          bus.cpuIdOut    <= mux_bus_pkg::BYTE_ZERO;
          bus.cpuIdOe     <= mux_bus_pkg::OE_ALL;
        end
      endcase
    end
  end

  // Sequencing of the two-cycle port transfer.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state     <= ST_RUN;
      pendingOp <= mux_bus_pkg::BYTE_ZERO;
    end else if (fetchEnd) begin
      unique case (state)
        ST_RUN: begin
          if (fetched == mux_bus_pkg::PORT_TRANSFER_OP) begin // RL9 RL10
            state     <= ST_PORT_CMD;
            pendingOp <= mux_bus_pkg::BYTE_ZERO;
          end else begin
            pendingOp <= fetched;
          end
        end
        ST_PORT_CMD: begin
          if (bus.writeIoLine) begin // RL11
            state <= ST_PORT_XFER;
          end
        end
        ST_PORT_XFER: begin
          state <= ST_PORT_XFER;
        end
        default: begin
          state <= ST_RUN;
        end
      endcase
    end else if (exchangeEnd) begin
      pendingOp <= mux_bus_pkg::BYTE_ZERO;
      if (state == ST_PORT_XFER) begin // RL12
        state <= ST_RUN;
      end
    end
  end

  // Program counter and the two return stack levels.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      programCounter   <= RESET_PC;
      upperReturnStack <= mux_bus_pkg::STACK_RESET;
      lowerReturnStack <= mux_bus_pkg::STACK_RESET;
    end else if (fetchEnd) begin
      if (state == ST_PORT_CMD) begin
        if (bus.writeIoLine) begin // RL9
          programCounter <= nextPc;
        end
      end else if (state == ST_PORT_XFER) begin
        programCounter <= programCounter;
      end else if (fetched[7:6] == mux_bus_pkg::JUMP_PREFIX) begin // RL13
        programCounter <= {pageNumber, fetched[5:0]};
      end else if (fetched[7:6] == mux_bus_pkg::CALL_PREFIX) begin // RL16
        upperReturnStack <= nextPc;
        lowerReturnStack <= upperReturnStack;
        programCounter   <= {pageNumber, fetched[5:0]};
      end else if (fetched == mux_bus_pkg::RETURN_OP) begin // RL16
        programCounter   <= upperReturnStack;
        upperReturnStack <= lowerReturnStack;
      end else begin
        programCounter <= nextPc; // RL14
      end
    end
  end

  // Accumulator, secondary accumulator and RAM pointer.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      accumulator  <= mux_bus_pkg::ACC_RESET;
      secondaryAcc <= mux_bus_pkg::ACC_RESET;
      ramPointer   <= mux_bus_pkg::POINTER_RESET;
    end else begin
      if (exchangeEnd && (isExchange || state == ST_PORT_XFER)) begin // RL7 RL12 RL19
        accumulator <= busDigit;
      end else if (exchangeEnd && isSwap) begin // RL16
        accumulator  <= secondaryAcc;
        secondaryAcc <= accumulator;
      end else if (accLoad) begin
        accumulator <= accValue;
      end
      if (pointerLoad) begin
        ramPointer <= pointerValue;
      end
    end
  end

endmodule : bus_processor_end

//--- verilog/mux_bus_if.sv
// Shared bus lines between the processor end and the memory and I/O end.
`timescale 1ns/1ps
interface mux_bus_if;

  logic        clockA;
  logic        clockB;
  logic [11:0] addrBusLine; // RL1
  logic        writeIoLine; // RL1
  logic [7:0]  cpuIdOut;
  logic [7:0]  cpuIdOe;
  logic [7:0]  memIdOut;
  logic [7:0]  memIdOe;
  logic [7:0]  instrDataBusLine; // RL1

  // The processor wins a contended bit; an undriven bit reads as zero.
  assign instrDataBusLine = (cpuIdOut & cpuIdOe) | (memIdOut & memIdOe & ~cpuIdOe);

  modport cpu (
    input  clockA,
    input  clockB,
    output addrBusLine,
    output writeIoLine,
    output cpuIdOut,
    output cpuIdOe,
    input  instrDataBusLine
  );

  modport mem (
    input  clockA,
    input  clockB,
    input  addrBusLine,
    input  writeIoLine,
    output memIdOut,
    output memIdOe,
    input  instrDataBusLine
  );

endinterface : mux_bus_if

//--- verilog/mux_bus_pkg.sv
// Constants, types and phase decoding shared by both ends of the multiplexed bus.
// How it works
// RL1 - Twelve address, eight data, one write line
// RL2 - Processor drives twelve address lines, 4096 locations
// RL3 - ROM has two selects, RAM one
// RL4 - Selects driven straight from discrete outputs
// RL5 - Write line high in phase two writes RAM
// RL6 - RAM always reads, writes only on command
// RL7 - Phase two: nibble read and nibble write together
// RL8 - I/O enable in phase four disables RAM
// RL9 - I/O transfer takes two cycles, two locations
// RL10 - First cycle fetches and decodes transfer opcode
// RL11 - Second cycle: enable raised, command byte selects
// RL12 - Data exchange in following phase two
// RL13 - Pages of 64, low six bits locate
// RL14 - Twelve-bit counter, top six bits page
// RL15 - RAM pointer split into three digits
// RL16 - Two return stacks, accumulator and secondary accumulator
// RL17 - Four phases derived from two clocks
// RL18 - Transfers in phases two, four; else zero
// RL19 - Accumulator data inverted across the bus
// RL20 - Write line low leaves RAM unchanged
package mux_bus_pkg;

  localparam int ADDR_W     = 12;
  localparam int DATA_W     = 8;
  localparam int DIGIT_W    = 4;
  localparam int LINE_COUNT = ADDR_W + DATA_W + 1;
  localparam int MEM_DEPTH  = 4096;
  localparam int PAGE_W     = 6;
  localparam int PAGE_SIZE  = 64;

  localparam int LOW_DIGIT_LSB  = 0;
  localparam int MID_DIGIT_LSB  = 4;
  localparam int HIGH_DIGIT_LSB = 8;
  localparam int PAGE_LSB       = 6;
  localparam int IO_SEL_LSB     = 4;

  localparam logic [11:0] PC_RESET      = 12'h000;
  localparam logic [11:0] POINTER_RESET = 12'h000;
  localparam logic [11:0] STACK_RESET   = 12'h000;
  localparam logic [3:0]  ACC_RESET     = 4'h0;
  localparam logic [7:0]  BYTE_ZERO     = 8'h00;

  localparam logic [7:0] OE_NONE      = 8'h00;
  localparam logic [7:0] OE_ALL       = 8'hFF;
  localparam logic [7:0] OE_LOW_HALF  = 8'h0F;
  localparam logic [7:0] OE_HIGH_HALF = 8'hF0;

  localparam logic [7:0] PORT_TRANSFER_OP = 8'h1C;
  localparam logic [7:0] EXCHANGE_OP      = 8'h2D;
  localparam logic [7:0] SWAP_ACC_OP      = 8'h1A;
  localparam logic [7:0] RETURN_OP        = 8'h05;
  localparam logic [1:0] JUMP_PREFIX      = 2'h2;
  localparam logic [1:0] CALL_PREFIX      = 2'h3;

  typedef enum logic [1:0] {PH1, PH2, PH3, PH4} phase_e;

  // Clock A high splits into phases one and two, low into three and four; clock B marks the first of each pair.
  function automatic phase_e decode_phase(input logic clockA, input logic clockB);
    phase_e result;
    if (clockA && clockB) begin
      result = PH1;
    end else if (clockA) begin
      result = PH2;
    end else if (clockB) begin
      result = PH3;
    end else begin
      result = PH4;
    end
    return result;
  endfunction : decode_phase

endpackage : mux_bus_pkg

//--- verilog/two_entry_buffer.sv
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/1ps
module two_entry_buffer #(
  parameter int WIDTH = 4
) (
  // Clock and reset.
  input  wire logic             sys_clk,
  input  wire logic             resetn,
  // Filling side.
  input  wire logic             inValid,
  output wire logic             inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Draining side.
  output wire logic             outValid,
  input  wire logic             outReady,
  output wire logic [WIDTH-1:0] outData
);

  logic [WIDTH-1:0] slot [2];
  logic             writePtr;
  logic             readPtr;
  logic [1:0]       count;
  logic             push;
  logic             pop;

  assign inReady  = (count != 2'h2);
  assign outValid = (count != 2'h0);
  assign outData  = slot[readPtr];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_ff @(posedge sys_clk) begin
    if (push) begin
      slot[writePtr] <= inData;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      writePtr <= 1'b0;
      readPtr  <= 1'b0;
      count    <= 2'h0;
    end else begin
      if (push) begin
        writePtr <= ~writePtr;
      end
      if (pop) begin
        readPtr <= ~readPtr;
      end
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule : two_entry_buffer
